// ### logic/sfsfe_defs.svh
`ifndef SFSFE_DEFS_SVH
`define SFSFE_DEFS_SVH

// Register byte offsets on the APB slave.
`define SFSFE_OFF_CTRL       12'h000
`define SFSFE_OFF_STATUS     12'h004
`define SFSFE_OFF_IRQ_STAT   12'h008
`define SFSFE_OFF_IRQ_MASK   12'h00c
`define SFSFE_OFF_ERASE_INFO 12'h010
`define SFSFE_OFF_LAST_CMD   12'h014

// Control register fields.
`define SFSFE_CTRL_BUSY 0
`define SFSFE_CTRL_WEL  1
`define SFSFE_CTRL_AAI  2
`define SFSFE_CTRL_RBEN 3
`define SFSFE_CTRL_W    4

// Interrupt status fields.
`define SFSFE_IRQ_SRW_DONE 0
`define SFSFE_IRQ_SRW_REJ  1
`define SFSFE_IRQ_ERASE    2
`define SFSFE_IRQ_ERASE_RJ 3
`define SFSFE_IRQ_FRAME    4
`define SFSFE_IRQ_W        5

// Primary status byte fields.
`define SFSFE_SR_BUSY     0
`define SFSFE_SR_WEL      1
`define SFSFE_SR_GUARD_LO 2
`define SFSFE_SR_GUARD_HI 3
`define SFSFE_SR_AAI      6
`define SFSFE_SR_LOCK     7

// Second status byte fields.
`define SFSFE_SR1_TOP 2
`define SFSFE_SR1_BOT 3

// Reset values of the protection bits.
`define SFSFE_GUARD_RST 2'b11
`define SFSFE_LOCK_RST  1'b0
`define SFSFE_SECT_RST  1'b0

// Synchroniser reset: {sck, cs_n, si, hold_n, wp_n}.
`define SFSFE_SYNC_RST 5'h0b

// Bit counts at which a field of the sequence is complete; the last is where the count stops.
`define SFSFE_CMD_LAST   6'h07
`define SFSFE_SRW_LAST   6'h0f
`define SFSFE_ERASE_LAST 6'h1f
`define SFSFE_CNT_MAX    6'h3f

// Instruction codes.
`define SFSFE_OP_SR_WRITE  8'h01
`define SFSFE_OP_SR_READ   8'h05
`define SFSFE_OP_SR1_WRITE 8'h31
`define SFSFE_OP_SR1_READ  8'h35
`define SFSFE_OP_ERASE_4K  8'h20
`define SFSFE_OP_ERASE_32K 8'h52
`define SFSFE_OP_ERASE_64K 8'hd8

`endif

// ### logic/sfsfe_pkg.sv
package sfsfe_pkg;

	typedef enum logic [2:0] {
		SFSFE_LS_IDLE   = 3'b001,
		SFSFE_LS_ACTIVE = 3'b010,
		SFSFE_LS_PAUSED = 3'b100
	} sfsfe_link_t;

	typedef enum logic [1:0] {
		SFSFE_ER_4K  = 2'h0,
		SFSFE_ER_32K = 2'h1,
		SFSFE_ER_64K = 2'h2
	} sfsfe_erase_t;

endpackage : sfsfe_pkg

// ### logic/sfsfe_top.sv
// Functional notes
// - Serial input bits are captured on each rising serial clock edge.
// - Serial output changes after each falling serial clock edge.
// - Clock idling low or high both work; same sampling and driving edges.
// - Select falling starts a sequence; select rising ends it.
// - In auto-increment mode, deselected output reports ready or busy.
// - Pause is honoured only while select is low.
// - Pause starts when pause input is low during clock low phase.
// - Pause ends when pause input is high during clock low phase.
// - While paused the output floats and clock and input are ignored.
// - Select rising while paused returns to standby; else pause holds.
// - Pause keeps the bit position; shifting resumes from the same point.
// - Status write rejected when protect pin low and lock bit set.
// - Erase in 4K sectors and overlaid 32K and 64K blocks.
// - Guard bits, lock and sector locks protect array and status.
// - Lock bit clears to zero at power-up.
// - Both array guard bits set to one at power-up.
//
// The APB register port and the address map were left to the implementer.
`include "sfsfe_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sfsfe_top #(
	parameter int ADDR_W        = 18,
	parameter int SECTOR_BYTES  = 4096,
	parameter int BLOCK32_BYTES = 32768,
	parameter int BLOCK64_BYTES = 65536
) (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// APB slave.
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link pins.
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        si,
	input  wire logic        hold_n,
	input  wire logic        wp_n,
	output logic             so,
	output logic             so_oe,
	// Interrupt.
	output logic             irq
);

	localparam logic [ADDR_W:0] ARRAY_SIZE = {1'b1, {ADDR_W{1'b0}}};
	localparam logic [ADDR_W:0] SEC_SIZE   = (ADDR_W+1)'(SECTOR_BYTES);
	localparam logic [ADDR_W:0] B32_SIZE   = (ADDR_W+1)'(BLOCK32_BYTES);
	localparam logic [ADDR_W:0] B64_SIZE   = (ADDR_W+1)'(BLOCK64_BYTES);

	logic [4:0]            meta_reg;
	logic [4:0]            sync_reg;
	logic                  sck_d_reg;
	sfsfe_pkg::sfsfe_link_t link_reg;
	sfsfe_pkg::sfsfe_link_t link_next;
	logic [5:0]            bit_cnt_reg;
	logic [31:0]           rx_reg;
	logic [31:0]           rx_next;
	logic [7:0]            cmd_reg;
	logic [7:0]            tx_reg;
	logic                  tx_active_reg;
	logic                  so_live_reg;
	logic [1:0]            guard_reg;
	logic                  lock_reg;
	logic                  top_lock_reg;
	logic                  bot_lock_reg;
	logic [`SFSFE_CTRL_W-1:0] ctrl_reg;
	logic [`SFSFE_IRQ_W-1:0]  irq_stat_reg;
	logic [`SFSFE_IRQ_W-1:0]  irq_stat_next;
	logic [`SFSFE_IRQ_W-1:0]  irq_mask_reg;
	logic [`SFSFE_IRQ_W-1:0]  irq_evt;
	logic [ADDR_W-1:0]     erase_base_reg;
	logic [1:0]            erase_size_reg;
	logic                  sck_s;
	logic                  cs_s;
	logic                  si_s;
	logic                  hold_s;
	logic                  wp_s;
	logic                  sck_rise;
	logic                  sck_fall;
	logic                  shift_en;
	logic                  rx_rise;
	logic                  tx_fall;
	logic                  cmd_done;
	logic                  srw_done;
	logic                  erase_done;
	logic                  sr_write_ok;
	logic                  rb_mode;
	logic                  frame_end;
	logic [7:0]            status_byte;
	logic [7:0]            status1_byte;
	logic [ADDR_W:0]       er_size;
	logic [ADDR_W:0]       er_base;
	logic [ADDR_W:0]       er_last;
	logic [ADDR_W:0]       prot_start;
	logic [1:0]            er_code;
	logic                  is_erase;
	logic                  er_hit;
	logic                  apb_setup;
	logic                  apb_commit;
	logic                  wr_en;
	logic [31:0]           rd_data;
	logic                  rd_err;

	// Every serial link input pin is brought into the sys_clk domain through two flip-flops.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= `SFSFE_SYNC_RST;
			sync_reg <= `SFSFE_SYNC_RST;
		end else begin
			meta_reg <= {sck, cs_n, si, hold_n, wp_n};
			sync_reg <= meta_reg;
		end
	end

	assign sck_s  = sync_reg[4];
	assign cs_s   = sync_reg[3];
	assign si_s   = sync_reg[2];
	assign hold_s = sync_reg[1];
	assign wp_s   = sync_reg[0];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sck_d_reg <= 1'b0;
		end else begin
			sck_d_reg <= sck_s;
		end
	end

	// Edges are found the same way whatever level the clock idles at.
	assign sck_rise = sck_s & ~sck_d_reg;
	assign sck_fall = ~sck_s & sck_d_reg;

	always_comb begin
		link_next = link_reg;
		case (link_reg)
			sfsfe_pkg::SFSFE_LS_IDLE: begin
				if (!cs_s) begin
					link_next = sfsfe_pkg::SFSFE_LS_ACTIVE;
				end
			end
			sfsfe_pkg::SFSFE_LS_ACTIVE: begin
				if (cs_s) begin
					link_next = sfsfe_pkg::SFSFE_LS_IDLE;
				end else if (!hold_s && !sck_s) begin
					link_next = sfsfe_pkg::SFSFE_LS_PAUSED;
				end
			end
			sfsfe_pkg::SFSFE_LS_PAUSED: begin
				if (cs_s) begin
					link_next = sfsfe_pkg::SFSFE_LS_IDLE;
				end else if (hold_s && !sck_s) begin
					link_next = sfsfe_pkg::SFSFE_LS_ACTIVE;
				end
			end
			default: begin
				link_next = sfsfe_pkg::SFSFE_LS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			link_reg <= sfsfe_pkg::SFSFE_LS_IDLE;
		end else begin
			link_reg <= link_next;
		end
	end

	// Clock edges are dropped while paused or deselected.
	assign shift_en   = (link_reg == sfsfe_pkg::SFSFE_LS_ACTIVE) & ~cs_s;
	assign rx_rise    = shift_en & sck_rise;
	assign tx_fall    = shift_en & sck_fall;
	assign rx_next    = {rx_reg[30:0], si_s};
	assign cmd_done   = rx_rise & (bit_cnt_reg == `SFSFE_CMD_LAST);
	assign srw_done   = rx_rise & (bit_cnt_reg == `SFSFE_SRW_LAST) &
		((cmd_reg == `SFSFE_OP_SR_WRITE) | (cmd_reg == `SFSFE_OP_SR1_WRITE));
	assign is_erase   = (cmd_reg == `SFSFE_OP_ERASE_4K) | (cmd_reg == `SFSFE_OP_ERASE_32K) |
		(cmd_reg == `SFSFE_OP_ERASE_64K);
	assign erase_done = rx_rise & (bit_cnt_reg == `SFSFE_ERASE_LAST) & is_erase;
	assign frame_end  = cs_s & (link_reg != sfsfe_pkg::SFSFE_LS_IDLE);

	// The bit position survives a pause because only shift_en moves it.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_reg <= 6'h00;
			rx_reg      <= 32'h0000_0000;
			cmd_reg     <= 8'h00;
		end else if (cs_s) begin
			bit_cnt_reg <= 6'h00;
		end else if (rx_rise) begin
			rx_reg <= rx_next;
			if (bit_cnt_reg != `SFSFE_CNT_MAX) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
			if (cmd_done) begin
				cmd_reg <= rx_next[7:0];
			end
		end
	end

	assign status_byte = {lock_reg, ctrl_reg[`SFSFE_CTRL_AAI], 2'b00, guard_reg,
		ctrl_reg[`SFSFE_CTRL_WEL], ctrl_reg[`SFSFE_CTRL_BUSY]};
	assign status1_byte = {4'h0, bot_lock_reg, top_lock_reg, 2'b00};

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_reg        <= 8'h00;
			tx_active_reg <= 1'b0;
		end else if (cs_s) begin
			tx_active_reg <= 1'b0;
		end else if (cmd_done && rx_next[7:0] == `SFSFE_OP_SR_READ) begin
			tx_reg        <= status_byte;
			tx_active_reg <= 1'b1;
		end else if (cmd_done && rx_next[7:0] == `SFSFE_OP_SR1_READ) begin
			tx_reg        <= status1_byte;
			tx_active_reg <= 1'b1;
		end else if (tx_fall && tx_active_reg) begin
			tx_reg <= {tx_reg[6:0], tx_reg[7]};
		end
	end

	assign rb_mode = ctrl_reg[`SFSFE_CTRL_AAI] & ctrl_reg[`SFSFE_CTRL_RBEN] & cs_s;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			so    <= 1'b0;
			so_oe <= 1'b0;
		end else if (rb_mode) begin
			so    <= ~ctrl_reg[`SFSFE_CTRL_BUSY];
			so_oe <= 1'b1;
		end else if (cs_s || link_reg != sfsfe_pkg::SFSFE_LS_ACTIVE) begin
			so_oe <= 1'b0;
		end else if (tx_fall && tx_active_reg) begin
			so    <= tx_reg[7];
			so_oe <= 1'b1;
		end else begin
			so_oe <= so_live_reg;
		end
	end

	// Remembers that a data bit is on the line, so the end of a pause drives it again.
	// It also keeps a ready/busy drive from lingering once select falls.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			so_live_reg <= 1'b0;
		end else if (cs_s) begin
			so_live_reg <= 1'b0;
		end else if (tx_fall && tx_active_reg) begin
			so_live_reg <= 1'b1;
		end
	end

	assign sr_write_ok = wp_s | ~lock_reg;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			guard_reg    <= `SFSFE_GUARD_RST;
			lock_reg     <= `SFSFE_LOCK_RST;
			top_lock_reg <= `SFSFE_SECT_RST;
			bot_lock_reg <= `SFSFE_SECT_RST;
		end else if (srw_done && sr_write_ok) begin
			if (cmd_reg == `SFSFE_OP_SR_WRITE) begin
				guard_reg <= {rx_next[`SFSFE_SR_GUARD_HI], rx_next[`SFSFE_SR_GUARD_LO]};
				lock_reg  <= rx_next[`SFSFE_SR_LOCK];
			end else begin
				top_lock_reg <= rx_next[`SFSFE_SR1_TOP];
				bot_lock_reg <= rx_next[`SFSFE_SR1_BOT];
			end
		end
	end

	// Erase range is the addressed unit aligned down to its own size.
	always_comb begin
		er_size = SEC_SIZE;
		er_code = sfsfe_pkg::SFSFE_ER_4K;
		if (cmd_reg == `SFSFE_OP_ERASE_32K) begin
			er_size = B32_SIZE;
			er_code = sfsfe_pkg::SFSFE_ER_32K;
		end else if (cmd_reg == `SFSFE_OP_ERASE_64K) begin
			er_size = B64_SIZE;
			er_code = sfsfe_pkg::SFSFE_ER_64K;
		end
		er_base = {1'b0, rx_next[ADDR_W-1:0]} & ~(er_size - 1'b1);
		er_last = er_base + er_size - 1'b1;
		case (guard_reg)
			2'b01:   prot_start = ARRAY_SIZE - (ARRAY_SIZE >> 2);
			2'b10:   prot_start = ARRAY_SIZE >> 1;
			2'b11:   prot_start = '0;
			default: prot_start = ARRAY_SIZE;
		endcase
		er_hit = (er_last >= prot_start) |
			(top_lock_reg & (er_last >= ARRAY_SIZE - SEC_SIZE)) |
			(bot_lock_reg & (er_base < SEC_SIZE));
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			erase_base_reg <= '0;
			erase_size_reg <= 2'h0;
		end else if (erase_done && !er_hit) begin
			erase_base_reg <= er_base[ADDR_W-1:0];
			erase_size_reg <= er_code;
		end
	end

	always_comb begin
		irq_evt = '0;
		irq_evt[`SFSFE_IRQ_SRW_DONE] = srw_done & sr_write_ok;
		irq_evt[`SFSFE_IRQ_SRW_REJ]  = srw_done & ~sr_write_ok;
		irq_evt[`SFSFE_IRQ_ERASE]    = erase_done & ~er_hit;
		irq_evt[`SFSFE_IRQ_ERASE_RJ] = erase_done & er_hit;
		irq_evt[`SFSFE_IRQ_FRAME]    = frame_end;
	end

	// APB: one wait state; the commit edge is where pready is sampled high.
	assign apb_setup  = psel & penable & ~pready;
	assign apb_commit = psel & penable & pready;
	assign wr_en      = apb_commit & pwrite & pstrb[0];

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		case (paddr)
			`SFSFE_OFF_CTRL:       rd_data[`SFSFE_CTRL_W-1:0] = ctrl_reg;
			`SFSFE_OFF_STATUS:     rd_data[18:0] = {wp_s, ~cs_s,
				link_reg == sfsfe_pkg::SFSFE_LS_PAUSED, status1_byte, status_byte};
			`SFSFE_OFF_IRQ_STAT:   rd_data[`SFSFE_IRQ_W-1:0] = irq_stat_reg;
			`SFSFE_OFF_IRQ_MASK:   rd_data[`SFSFE_IRQ_W-1:0] = irq_mask_reg;
			`SFSFE_OFF_ERASE_INFO: rd_data[25:0] = {erase_size_reg, 6'h00,
				(ADDR_W <= 18) ? 18'(erase_base_reg) : 18'h00000};
			`SFSFE_OFF_LAST_CMD:   rd_data[7:0] = cmd_reg;
			default:               rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_setup;
			prdata  <= (apb_setup && !pwrite) ? rd_data : 32'h0000_0000;
			pslverr <= apb_setup & rd_err;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg     <= '0;
			irq_mask_reg <= '0;
		end else if (wr_en && paddr == `SFSFE_OFF_CTRL) begin
			ctrl_reg <= pwdata[`SFSFE_CTRL_W-1:0];
		end else if (wr_en && paddr == `SFSFE_OFF_IRQ_MASK) begin
			irq_mask_reg <= pwdata[`SFSFE_IRQ_W-1:0];
		end
	end

	// A new event outranks a simultaneous write-one-to-clear.
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_en && paddr == `SFSFE_OFF_IRQ_STAT) begin
			irq_stat_next = irq_stat_reg & ~pwdata[`SFSFE_IRQ_W-1:0];
		end
		irq_stat_next = irq_stat_next | irq_evt;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_stat_reg <= '0;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq          <= |(irq_stat_next & irq_mask_reg);
		end
	end

endmodule : sfsfe_top

`default_nettype wire

// ### tb/sfsfe_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sfsfe_checker (
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        rstn,
	// APB slave.
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Link and interrupt.
	input wire logic        sck,
	input wire logic        cs_n,
	input wire logic        hold_n,
	input wire logic        so,
	input wire logic        so_oe,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_answer; psel && penable && !pready |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("access not answered in one cycle");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held longer than one cycle");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_idle; !pready |-> prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data not zero while idle");
	property p_unmapped; pready && paddr > 12'h014 |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped; pready && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	property p_hold; (!cs_n && !hold_n && !sck) [*6] |-> !so_oe; endproperty
	a_hold: assert property (p_hold) else $error("output driven while paused");
	property p_so_edge; so_oe && $past(so_oe) && !cs_n && $changed(so) |-> !sck; endproperty
	a_so_edge: assert property (p_so_edge) else $error("output moved in clock high");
	property p_quiet; $rose(rstn) |-> !pready && !so_oe && !irq; endproperty
	a_quiet: assert property (p_quiet) else $error("outputs active after reset");
endmodule : sfsfe_checker
bind sfsfe_top sfsfe_checker sfsfe_checker_i (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sck(sck), .cs_n(cs_n), .hold_n(hold_n), .so(so), .so_oe(so_oe), .irq(irq));
`default_nettype wire

// ### tb/sfsfe_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfsfe_host_model (
	// Serial link.
	output var logic sck,
	output var logic cs_n,
	output var logic si,
	output var logic hold_n,
	input wire logic so_line
);
	logic cpol = 1'b0;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
	end
	// The clock idles at the chosen level; both modes use the same edges.
	task automatic start(input logic pol);
		cpol = pol;
		sck = pol;
		#100 cs_n = 1'b0;
		#32;
	endtask : start
	// Bits go out before the rising edge and come back on it, top bit first.
	task automatic shift(input logic [7:0] tx, input int hi, input int lo, inout logic [7:0] rx);
		for (int i = hi; i >= lo; i--) begin
			sck = 1'b0;
			si = tx[i];
			#32 sck = 1'b1;
			rx[i] = so_line;
			#32;
		end
	endtask : shift
	task automatic stop();
		if (!cpol) sck = 1'b0;
		#32 cs_n = 1'b1;
		si = ~si;
		#100;
	endtask : stop
	// The clock and input wander while paused; the device must ignore them.
	task automatic hold_on();
		sck = 1'b0;
		#8 hold_n = 1'b0;
		repeat (2) begin
			si = ~si;
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
		#60;
	endtask : hold_on
	task automatic hold_off();
		hold_n = 1'b1;
		#100;
	endtask : hold_off
endmodule : sfsfe_host_model
`default_nettype wire

// ### tb/sfsfe_top_bench.sv
`include "sfsfe_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module sfsfe_top_bench;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic        wp_n = 1'b1;
	logic        so_last = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, so, so_oe, irq, sck, cs_n, si, hold_n;
	logic [7:0]  rx;
	int          num_errors = 0;
	int          check_count = 0;
	// A released output line shows the opposite of its last driven level.
	wire so_line = so_oe ? so : ~so_last;
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (so_oe) so_last <= so;
	sfsfe_top sfsfe_top_i (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
		.wp_n(wp_n), .so(so), .so_oe(so_oe), .irq(irq));
	sfsfe_host_model sfsfe_host_model_i (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
		.so_line(so_line));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge sys_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		logic x;
		apb(1'b0, a, 32'h0, r, x);
		chk(r & m, e);
		chk({31'h0, x}, 32'h0);
	endtask : rchk
	task automatic send(input logic pol, input logic [31:0] w, input int nb);
		logic [7:0] r;
		@(negedge sys_clk);
		sfsfe_host_model_i.start(pol);
		for (int b = 3; b > 3 - nb; b--) sfsfe_host_model_i.shift(w[8*b+:8], 7, 0, r);
		sfsfe_host_model_i.stop();
	endtask : send
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rchk(`SFSFE_OFF_STATUS, 32'hffff, 32'h000c);
		apb(1'b0, 12'h018, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_status_write();
		send(1'b1, 32'h01800000, 2);
		rchk(`SFSFE_OFF_STATUS, 32'hff, 32'h80);
		rchk(`SFSFE_OFF_IRQ_STAT, 32'h1f, 32'h11);
		chk({31'h0, irq}, 32'h0);
		wr(`SFSFE_OFF_IRQ_MASK, 32'h1f);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		wr(`SFSFE_OFF_IRQ_STAT, 32'h1f);
		@(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		wp_n <= 1'b0;
		send(1'b0, 32'h010c0000, 2);
		rchk(`SFSFE_OFF_STATUS, 32'hff, 32'h80);
		rchk(`SFSFE_OFF_IRQ_STAT, 32'h1f, 32'h12);
		wp_n <= 1'b1;
		send(1'b0, 32'h01000000, 2);
		rchk(`SFSFE_OFF_STATUS, 32'hff, 32'h00);
		wr(`SFSFE_OFF_IRQ_STAT, 32'h1f);
		$display("test status write done");
	endtask : t_status_write
	task automatic t_erase();
		logic [7:0]  op[3] = '{8'h20, 8'h52, 8'hd8};
		logic [31:0] ex[3] = '{32'h0001a000, 32'h01018000, 32'h02010000};
		for (int k = 0; k < 3; k++) begin
			send(1'b0, {op[k], 24'h01abcd}, 4);
			rchk(`SFSFE_OFF_ERASE_INFO, 32'h033fffff, ex[k]);
		end
		send(1'b0, 32'h01040000, 2);
		wr(`SFSFE_OFF_IRQ_STAT, 32'h1f);
		send(1'b0, 32'h2003f000, 4);
		rchk(`SFSFE_OFF_IRQ_STAT, 32'h1f, 32'h18);
		rchk(`SFSFE_OFF_ERASE_INFO, 32'h033fffff, 32'h02010000);
		send(1'b0, 32'h310c0000, 2);
		rchk(`SFSFE_OFF_STATUS, 32'hff00, 32'h0c00);
		wr(`SFSFE_OFF_IRQ_STAT, 32'h1f);
		send(1'b0, 32'h20000100, 4);
		rchk(`SFSFE_OFF_IRQ_STAT, 32'h1f, 32'h18);
		rchk(`SFSFE_OFF_LAST_CMD, 32'hff, 32'h20);
		$display("test erase done");
	endtask : t_erase
	task automatic t_hold_read();
		wr(`SFSFE_OFF_CTRL, 32'h3);
		@(negedge sys_clk);
		sfsfe_host_model_i.start(1'b0);
		sfsfe_host_model_i.shift(8'h05, 7, 0, rx);
		sfsfe_host_model_i.shift(8'h00, 7, 4, rx);
		sfsfe_host_model_i.hold_on();
		chk({31'h0, so_oe}, 32'h0);
		rchk(`SFSFE_OFF_STATUS, 32'h10000, 32'h10000);
		@(negedge sys_clk);
		sfsfe_host_model_i.hold_off();
		rchk(`SFSFE_OFF_STATUS, 32'h10000, 32'h0);
		@(negedge sys_clk);
		sfsfe_host_model_i.shift(8'h00, 3, 0, rx);
		sfsfe_host_model_i.stop();
		chk({24'h0, rx}, 32'h07);
		sfsfe_host_model_i.start(1'b0);
		sfsfe_host_model_i.shift(8'h05, 7, 4, rx);
		sfsfe_host_model_i.hold_on();
		sfsfe_host_model_i.stop();
		rchk(`SFSFE_OFF_STATUS, 32'h30000, 32'h0);
		@(negedge sys_clk);
		sfsfe_host_model_i.hold_off();
		sfsfe_host_model_i.hold_on();
		rchk(`SFSFE_OFF_STATUS, 32'h30000, 32'h0);
		@(negedge sys_clk);
		sfsfe_host_model_i.hold_off();
		$display("test hold read done");
	endtask : t_hold_read
	task automatic t_ready_busy();
		wr(`SFSFE_OFF_CTRL, 32'hd);
		repeat (6) @(posedge sys_clk);
		chk({30'h0, so_oe, so}, 32'h2);
		wr(`SFSFE_OFF_CTRL, 32'hc);
		repeat (6) @(posedge sys_clk);
		chk({30'h0, so_oe, so}, 32'h3);
		wr(`SFSFE_OFF_CTRL, 32'h0);
		$display("test ready busy done");
	endtask : t_ready_busy
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_status_write();
		t_erase();
		t_hold_read();
		t_ready_busy();
		end_of_test();
	end
	initial begin
		#300000;
		num_errors++;
		end_of_test();
	end
endmodule : sfsfe_top_bench
`default_nettype wire
